//--- design/sfws_flash.sv
// Flash array with write and erase sequencing
// Overview of operation
// RL1 - Accepts requests from JTAG port, bootloader and CPU, one at a time.
// RL2 - CPU writes program a single byte or a single 16-bit word.
// RL3 - Main array is n segments of 512 bytes; segment erase is smallest.
// RL4 - Two information segments, A and B, of 128 bytes each.
// RL5 - Erase one main segment, or all main segments at once.
// RL6 - Erase info A or B alone; group erase clears info with all main.
// RL7 - Controller should erase information memory before first use; this module erases only when a request asks for it.
// RL8 - Erased bytes read back 0xFF until programmed again.
`timescale 1ns/1ps
module sfws_flash
	import sfws_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  arst_n,
	// Requests, one per source
	input  wire logic [2:0]            req_valid,
	output logic [2:0]                 req_ready,
	input  wire sfws_pkg::sfws_op_t    req_op [3],
	input  wire logic [sfws_pkg::ADDR_W-1:0] req_addr [3],
	input  wire logic [15:0]           req_wdata [3],
	input  wire logic                  req_info [3],
	// Read port
	input  wire logic [sfws_pkg::ADDR_W-1:0] rd_addr,
	input  wire logic                  rd_info,
	output logic [7:0]                 rd_data,
	// Status
	output logic                       busy,
	output logic                       done,
	output sfws_pkg::sfws_src_t        done_src
);
	import sfws_pkg::*;

	typedef enum {ST_IDLE, ST_ERASE} sfws_state_t;

	logic [1:0]        rst_sync_reg;
	logic              rst_n;
	logic [7:0]        main_mem [MAIN_BYTES];
	logic [7:0]        info_mem [INFO_BYTES];
	sfws_state_t       state_reg, state_next;
	sfws_op_t          op_reg, op_next;
	logic [ADDR_W-1:0] cnt_reg, cnt_next;
	logic [ADDR_W-1:0] base_reg, base_next;
	logic [ADDR_W-1:0] last_reg, last_next;
	logic              einfo_reg, einfo_next;
	sfws_src_t         src_reg, src_next;
	logic              done_reg, done_next;
	logic [1:0]        grant;
	logic              any_req;
	logic              wr_en, wr_word, wr_info;
	logic [ADDR_W-1:0] wr_addr;
	logic [15:0]       wr_data;
	logic              er_en, er_info;
	logic [ADDR_W-1:0] er_addr;
	logic [ADDR_W-1:0] all_cnt_reg, all_cnt_next;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// Fixed priority JTAG, bootloader, CPU; keeps test access deterministic
	always_comb begin
		grant   = 2'h0;
		any_req = 1'b0;
		for (int i = 2; i >= 0; i--) begin
			if (req_valid[i]) begin
				grant   = 2'(i);
				any_req = 1'b1;
			end
		end
		req_ready = '0;
		if (state_reg == ST_IDLE && any_req) begin
			req_ready[grant] = 1'b1; // RL1
		end
	end

	always_comb begin
		state_next = state_reg;
		op_next    = op_reg;
		cnt_next   = cnt_reg;
		base_next  = base_reg;
		last_next  = last_reg;
		einfo_next = einfo_reg;
		src_next   = src_reg;
		done_next  = 1'b0;
		wr_en      = 1'b0;
		wr_word    = 1'b0;
		wr_info    = req_info[grant];
		wr_addr    = req_addr[grant];
		wr_data    = req_wdata[grant];
		er_en      = 1'b0;
		er_info    = einfo_reg;
		er_addr    = base_reg + cnt_reg;
		case (state_reg)
			ST_IDLE: begin
				if (any_req) begin
					src_next = sfws_src_t'(grant);
					op_next  = req_op[grant];
					cnt_next = '0;
					case (req_op[grant])
						SFWS_OP_WR_BYTE: begin
							wr_en     = 1'b1; // RL2
							done_next = 1'b1;
						end
						SFWS_OP_WR_WORD: begin
							wr_en     = 1'b1; // RL2
							wr_word   = 1'b1;
							done_next = 1'b1;
						end
						SFWS_OP_ERASE_MAIN_SEG: begin
							base_next  = req_addr[grant] & ~ADDR_W'(MAIN_SEG_BYTES - 1); // RL3
							last_next  = ADDR_W'(MAIN_SEG_BYTES - 1);
							einfo_next = 1'b0;
							state_next = ST_ERASE;
						end
						SFWS_OP_ERASE_MAIN_ALL, SFWS_OP_ERASE_ALL: begin
							base_next  = '0; // RL5
							last_next  = ADDR_W'(MAIN_BYTES - 1);
							einfo_next = 1'b0;
							state_next = ST_ERASE;
						end
						SFWS_OP_ERASE_INFO_SEG: begin
							base_next  = req_addr[grant] & ~ADDR_W'(INFO_SEG_BYTES - 1); // RL4
							base_next  = base_next & ADDR_W'(INFO_BYTES - 1);
							last_next  = ADDR_W'(INFO_SEG_BYTES - 1); // RL6
							einfo_next = 1'b1;
							state_next = ST_ERASE;
						end
						default: done_next = 1'b1;
					endcase
				end
			end
			ST_ERASE: begin
				er_en    = 1'b1; // RL8
				cnt_next = cnt_reg + ADDR_W'(1);
				if (cnt_reg == last_reg) begin
					cnt_next = '0;
					if (op_reg == SFWS_OP_ERASE_ALL && !einfo_reg) begin
						base_next  = '0; // RL6
						last_next  = ADDR_W'(INFO_BYTES - 1);
						einfo_next = 1'b1;
					end else begin
						state_next = ST_IDLE;
						done_next  = 1'b1;
					end
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			op_reg    <= SFWS_OP_WR_BYTE;
			cnt_reg   <= '0;
			base_reg  <= '0;
			last_reg  <= '0;
			einfo_reg <= 1'b0;
			src_reg   <= SFWS_SRC_JTAG;
			done_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			op_reg    <= op_next;
			cnt_reg   <= cnt_next;
			base_reg  <= base_next;
			last_reg  <= last_next;
			einfo_reg <= einfo_next;
			src_reg   <= src_next;
			done_reg  <= done_next;
		end
	end

	// Array storage has no reset; contents survive like real flash
	always_ff @(posedge clk) begin
		if (er_en && er_info) begin
			info_mem[er_addr[INFO_IDX_W-1:0]] <= ERASED_BYTE; // RL8
		end else if (er_en) begin
			main_mem[er_addr[SEG_IDX_W+8:0]] <= ERASED_BYTE; // RL8
		end
		// Programming only clears bits, as flash cells do
		if (wr_en && wr_info) begin
			info_mem[wr_addr[INFO_IDX_W-1:0]] <=
				info_mem[wr_addr[INFO_IDX_W-1:0]] & wr_data[7:0];
			if (wr_word) begin
				info_mem[wr_addr[INFO_IDX_W-1:0] | 8'h01] <=
					info_mem[wr_addr[INFO_IDX_W-1:0] | 8'h01] & wr_data[15:8];
			end
		end else if (wr_en) begin
			main_mem[wr_addr[SEG_IDX_W+8:0]] <= main_mem[wr_addr[SEG_IDX_W+8:0]] & wr_data[7:0];
			if (wr_word) begin
				main_mem[wr_addr[SEG_IDX_W+8:0] | 13'h0001] <=
					main_mem[wr_addr[SEG_IDX_W+8:0] | 13'h0001] & wr_data[15:8];
			end
		end
	end

	always_ff @(posedge clk) begin
		rd_data <= rd_info ? info_mem[rd_addr[INFO_IDX_W-1:0]] : main_mem[rd_addr[SEG_IDX_W+8:0]];
	end

	// Cycle count of a group erase; too long for a delay range in a property
	always_comb begin
		all_cnt_next = all_cnt_reg;
		if (state_reg == ST_IDLE && any_req && req_op[grant] == SFWS_OP_ERASE_ALL) begin
			all_cnt_next = ADDR_W'(1);
		end else if (done_reg) begin
			all_cnt_next = '0;
		end else if (all_cnt_reg != '0) begin
			all_cnt_next = all_cnt_reg + ADDR_W'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			all_cnt_reg <= '0;
		end else begin
			all_cnt_reg <= all_cnt_next;
		end
	end

	assign busy     = (state_reg != ST_IDLE);
	assign done     = done_reg;
	assign done_src = src_reg;

	a_erase_seg_len: assert property (@(posedge clk) disable iff (!rst_n) // RL3
		(req_ready[grant] && req_op[grant] == SFWS_OP_ERASE_MAIN_SEG)
		|=> busy [*8] ##[1:600] done)
		else $error("segment erase length wrong");
	a_info_seg_len: assert property (@(posedge clk) disable iff (!rst_n) // RL4
		(req_ready[grant] && req_op[grant] == SFWS_OP_ERASE_INFO_SEG)
		|=> ##128 done)
		else $error("info segment erase length wrong");
	a_write_done: assert property (@(posedge clk) disable iff (!rst_n) // RL2
		(req_ready[grant] && req_op[grant] inside {SFWS_OP_WR_BYTE, SFWS_OP_WR_WORD})
		|=> done && !busy)
		else $error("write not single cycle");
	a_one_grant: assert property (@(posedge clk) disable iff (!rst_n) // RL1
		$onehot0(req_ready) && (!busy || req_ready == 3'h0))
		else $error("grant overlap");
	a_erase_value: assert property (@(posedge clk) disable iff (!rst_n) // RL8
		(er_en && !er_info) |=> main_mem[(SEG_IDX_W + 9)'($past(er_addr))] == ERASED_BYTE)
		else $error("erased byte not FF");
	a_all_erase_len: assert property (@(posedge clk) disable iff (!rst_n) // RL6
		(all_cnt_reg != '0)
		|-> (all_cnt_reg <= ADDR_W'(MAIN_BYTES + INFO_BYTES + 1))
			&& (done == (all_cnt_reg == ADDR_W'(MAIN_BYTES + INFO_BYTES + 1))))
		else $error("group erase length wrong");
	a_main_all_len: assert property (@(posedge clk) disable iff (!rst_n) // RL5
		(req_ready[grant] && req_op[grant] == SFWS_OP_ERASE_MAIN_ALL)
		|=> !done [*8])
		else $error("main erase ended early");
	a_src_kept: assert property (@(posedge clk) disable iff (!rst_n) // RL1
		busy |=> $stable(done_src))
		else $error("source changed while busy");
endmodule

//--- design/sfws_pkg.sv
// Constants and types for the segmented flash write and erase sequencer
package sfws_pkg;
	localparam int            ADDR_W        = 14;
	localparam int            MAIN_SEGS     = 16;
	localparam int            MAIN_SEG_BYTES = 512;
	localparam int            INFO_SEG_BYTES = 128;
	localparam int            INFO_SEGS     = 2;
	localparam int            MAIN_BYTES    = MAIN_SEGS * MAIN_SEG_BYTES;
	localparam int            INFO_BYTES    = INFO_SEGS * INFO_SEG_BYTES;
	localparam int            SEG_IDX_W     = 4;
	localparam int            INFO_IDX_W    = 8;
	localparam logic [7:0]    ERASED_BYTE   = 8'hFF;

	typedef enum logic [1:0] {
		SFWS_SRC_JTAG,
		SFWS_SRC_BOOT,
		SFWS_SRC_CPU
	} sfws_src_t;

	typedef enum logic [2:0] {
		SFWS_OP_WR_BYTE,
		SFWS_OP_WR_WORD,
		SFWS_OP_ERASE_MAIN_SEG,
		SFWS_OP_ERASE_MAIN_ALL,
		SFWS_OP_ERASE_INFO_SEG,
		SFWS_OP_ERASE_ALL
	} sfws_op_t;
endpackage

//--- testbench/sfws_requester.sv
// Requester model standing in for one programming source
`timescale 1ns/1ps
module sfws_requester
	import sfws_pkg::*;
(
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        arst_n,
	// Command from the bench
	input  wire logic                        start,
	input  wire sfws_pkg::sfws_op_t          op_in,
	input  wire logic [sfws_pkg::ADDR_W-1:0] addr_in,
	input  wire logic [15:0]                 data_in,
	input  wire logic                        info_in,
	// Request toward the flash
	input  wire logic                        ready,
	output logic                             valid,
	output sfws_pkg::sfws_op_t               op,
	output logic [sfws_pkg::ADDR_W-1:0]      addr,
	output logic [15:0]                      wdata,
	output logic                             info
);
	// Held until taken; addr and wdata inverted after so stale values never match
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			valid <= 1'b0;
		end else if (start) begin
			valid <= 1'b1;
			op    <= op_in;
			addr  <= addr_in;
			wdata <= data_in;
			info  <= info_in;
		end else if (valid && ready) begin
			valid <= 1'b0;
			addr  <= ~addr;
			wdata <= ~wdata;
		end
	end
endmodule

//--- testbench/tb_segmented_flash_write_erase.sv
// Self-checking bench for the flash sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb_segmented_flash_write_erase;
	import sfws_pkg::*;
	logic             clk, arst_n, busy, done;
	logic [2:0]       start, req_valid, req_ready;
	sfws_op_t         op_in [3], req_op [3];
	logic [13:0]      addr_in [3], req_addr [3], rd_addr, a;
	logic [15:0]      data_in [3], req_wdata [3], d;
	logic             info_in [3], req_info [3], rd_info;
	logic [7:0]       rd_data;
	sfws_src_t        done_src;
	int               n_errors, compares, seed, cyc;
	sfws_flash i_sfws_flash (.clk(clk), .arst_n(arst_n), .req_valid(req_valid),
		.req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
		.req_wdata(req_wdata), .req_info(req_info), .rd_addr(rd_addr),
		.rd_info(rd_info), .rd_data(rd_data), .busy(busy), .done(done),
		.done_src(done_src));
	for (genvar g = 0; g < 3; g++) begin : g_src
		sfws_requester u_req (.clk(clk), .arst_n(arst_n), .start(start[g]),
			.op_in(op_in[g]), .addr_in(addr_in[g]), .data_in(data_in[g]),
			.info_in(info_in[g]), .ready(req_ready[g]), .valid(req_valid[g]),
			.op(req_op[g]), .addr(req_addr[g]), .wdata(req_wdata[g]),
			.info(req_info[g]));
	end
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Edges from start to seen done: two to accept, then one per erased byte
	function automatic int span(input int n);
		return n + 2;
	endfunction
	task automatic tally_and_finish();
		$display("compares=%0d n_errors=%0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic issue(input int s, input sfws_op_t o, input logic [13:0] ad,
		input logic [15:0] dt, input logic inf, input int n);
		int k;
		op_in[s] = o;
		addr_in[s] = ad;
		data_in[s] = dt;
		info_in[s] = inf;
		start[s] = 1'b1;
		@(posedge clk);
		#1 start[s] = 1'b0;
		k = 1;
		while (done !== 1'b1 && k < 9000) begin
			@(posedge clk);
			#1 k++;
		end
		`CHK(k, span(n))
		`CHK(done_src, sfws_src_t'(s))
	endtask
	task automatic rd(input logic [13:0] ad, input logic inf, input logic [7:0] e);
		rd_addr = ad;
		rd_info = inf;
		@(posedge clk);
		#1 `CHK(rd_data, e)
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	initial begin
		seed = 65;
		start = '0;
		for (int i = 0; i < 3; i++) begin
			op_in[i] = SFWS_OP_WR_BYTE;
			addr_in[i] = '0;
			data_in[i] = '0;
			info_in[i] = 1'b0;
		end
		rd_addr = '0;
		rd_info = 1'b0;
		arst_n = 1'b0;
		repeat (20) @(posedge clk);
		#1 arst_n = 1'b1;
		repeat (4) @(posedge clk);
		#1 issue(0, SFWS_OP_ERASE_ALL, 0, 0, 0, MAIN_BYTES + INFO_BYTES);
		rd(14'h1FFF, 0, ERASED_BYTE);
		rd(14'h00FF, 1, ERASED_BYTE);
		$display("test erase_all done");
		for (int i = 0; i < 6; i++) begin
			d = 16'($random(seed));
			a = 14'(i * 37);
			issue(i % 3, SFWS_OP_WR_BYTE, a, d, 0, 0);
			rd(a, 0, d[7:0]);
		end
		issue(2, SFWS_OP_WR_WORD, 14'h0300, 16'hA55A, 0, 0);
		rd(14'h0300, 0, 8'h5A);
		rd(14'h0301, 0, 8'hA5);
		$display("test writes done");
		issue(1, SFWS_OP_WR_BYTE, 14'h01FF, 16'h0012, 0, 0);
		issue(1, SFWS_OP_WR_BYTE, 14'h0200, 16'h0034, 0, 0);
		issue(2, SFWS_OP_ERASE_MAIN_SEG, 14'h0100, 0, 0, MAIN_SEG_BYTES);
		rd(14'h01FF, 0, ERASED_BYTE);
		rd(14'h0200, 0, 8'h34);
		issue(0, SFWS_OP_WR_BYTE, 14'h007F, 16'h0000, 1, 0);
		issue(0, SFWS_OP_WR_BYTE, 14'h0080, 16'h0000, 1, 0);
		issue(1, SFWS_OP_ERASE_INFO_SEG, 14'h0010, 0, 0, INFO_SEG_BYTES);
		rd(14'h007F, 1, ERASED_BYTE);
		rd(14'h0080, 1, 8'h00);
		$display("test segment erase done");
		issue(2, SFWS_OP_ERASE_MAIN_ALL, 0, 0, 0, MAIN_BYTES);
		rd(14'h0200, 0, ERASED_BYTE);
		rd(14'h0080, 1, 8'h00);
		$display("test main erase done");
		// Two sources at once: the lower index is served first
		op_in[1] = SFWS_OP_WR_BYTE;
		addr_in[1] = 14'h0400;
		data_in[1] = 16'h00C3;
		info_in[1] = 1'b0;
		op_in[2] = SFWS_OP_WR_BYTE;
		addr_in[2] = 14'h0401;
		data_in[2] = 16'h003C;
		info_in[2] = 1'b0;
		start = 3'h6;
		@(posedge clk);
		#1 start = 3'h0;
		@(posedge clk);
		#1 `CHK(done_src, SFWS_SRC_BOOT)
		`CHK(done, 1'b1)
		@(posedge clk);
		#1 `CHK(done_src, SFWS_SRC_CPU)
		`CHK(done, 1'b1)
		rd(14'h0400, 0, 8'hC3);
		rd(14'h0401, 0, 8'h3C);
		$display("test priority done");
		// CPU erase of info B makes JTAG wait; JTAG is taken right after done
		op_in[2] = SFWS_OP_ERASE_INFO_SEG;
		addr_in[2] = 14'h00C0;
		op_in[0] = SFWS_OP_WR_BYTE;
		addr_in[0] = 14'h0081;
		data_in[0] = 16'h005A;
		info_in[0] = 1'b1;
		start = 3'h4;
		@(posedge clk);
		#1 start = 3'h1;
		@(posedge clk);
		#1 start = 3'h0;
		`CHK(busy, 1'b1)
		`CHK(req_ready, 3'h0)
		repeat (INFO_SEG_BYTES) @(posedge clk);
		#1 `CHK(done, 1'b1)
		`CHK(busy, 1'b0)
		`CHK(done_src, SFWS_SRC_CPU)
		@(posedge clk);
		#1 `CHK(done, 1'b1)
		`CHK(done_src, SFWS_SRC_JTAG)
		rd(14'h0081, 1, 8'h5A);
		rd(14'h0080, 1, ERASED_BYTE);
		$display("test wait while busy done");
		tally_and_finish();
	end
endmodule
